/* rrs_pkg.sv */
// Constants, types and register map for the return/rotate/sleep executor
// Summary of operation
// - Literal return loads W, pops PC, two cycles
// - Rotate right through carry; only carry changes
// - Destination bit 0 to W, 1 to file
// - Plain return pops stack into PC, two cycles
// - Sleep clears watchdog counter and prescaler
// - Sleep clears sleep flag, sets expired flag
// - Sleep halts oscillator and enters sleep state
// - Instruction cycle equals four oscillator periods
package rrs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_INSTR  = 8'h04;
  localparam logic [7:0] OFF_ACC    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_PUSH   = 8'h14;
  localparam logic [7:0] OFF_FADDR  = 8'h18;
  localparam logic [7:0] OFF_FDATA  = 8'h1c;
  localparam logic [7:0] OFF_WDOG   = 8'h20;

  // Control register bits
  localparam int CTRL_GO   = 0;
  localparam int CTRL_WAKE = 1;
  localparam int CTRL_BUSY = 0;
  localparam int CTRL_SLP  = 1;
  localparam int CTRL_OSC  = 2;

  // Status register bits
  localparam int ST_CARRY = 0;
  localparam int ST_SLEEP_ENTERED = 3;
  localparam int ST_TIME_EXPIRED  = 4;

  // Values after reset
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [12:0] PC_RST    = 13'h0000;
  localparam logic        CARRY_RST = 1'b0;
  localparam logic        SLEEP_ENTERED_RST = 1'b1;
  localparam logic        TIME_EXPIRED_RST  = 1'b1;

  // Oscillator periods in one instruction cycle
  localparam int          OSC_PER_TCY = 4;
  localparam logic [1:0]  Q_LAST      = 2'(OSC_PER_TCY - 1);

  localparam int PC_WIDTH = 13;

  typedef enum logic [2:0] {
    OP_NOP    = 3'h0,
    OP_RET_LITERAL  = 3'h1,
    OP_ROTATE_RIGHT = 3'h2,
    OP_RETURN = 3'h3,
    OP_SLEEP  = 3'h4
  } op_e;

  // Instruction word as written to the instruction register
  typedef struct packed {
    logic [7:0] lit;
    logic [6:0] faddr;
    logic       dest;
    op_e        op;
  } instr_s;

  localparam int INSTR_BITS = $bits(instr_s);

endpackage : rrs_pkg

/* return_stack.sv */
// Circular hardware return stack
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Stack operations
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  // Stack view
  output logic      [WIDTH-1:0] head,
  output logic      [7:0]       depth
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    ptr_q;
  logic [7:0]       cnt_q;
  wire  [PW-1:0]    top_idx = ptr_q - PW'(1);

  // Overflow wraps and overwrites the oldest entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= '0;
      cnt_q <= 8'h00;
    end else if (push) begin
      ptr_q <= ptr_q + PW'(1);
      if (cnt_q != 8'(DEPTH)) cnt_q <= cnt_q + 8'h01;
    end else if (pop) begin
      ptr_q <= top_idx;
      if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) mem_q[ptr_q] <= push_data;
  end

  assign head  = mem_q[top_idx];
  assign depth = cnt_q;

endmodule : return_stack

/* return_rotate_sleep_exec.sv */
// Executor for literal return, return, rotate right and sleep
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module return_rotate_sleep_exec #(
  parameter int FILE_DEPTH  = 128,
  parameter int STACK_DEPTH = 8,
  parameter int PRE_WIDTH   = 8,
  parameter int WDOG_WIDTH  = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power state
  output logic             sleeping,
  output logic             osc_run
);

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_SLEEP} state_e;

  localparam int PCW = rrs_pkg::PC_WIDTH;

  state_e                 state_q, state_d;
  logic [1:0]             q_q;
  logic                   cyc_q;
  logic                   pend_q;
  rrs_pkg::instr_s        ir_q, cur_q;
  logic [7:0]             w_q;
  logic                   c_q, sleep_entered_q, time_expired_q;
  logic [PCW-1:0]         pc_q;
  logic [7:0]             file_q [FILE_DEPTH];
  logic [6:0]             faddr_q;
  logic [PRE_WIDTH-1:0]   pre_q;
  logic [WDOG_WIDTH-1:0]  wdog_q;
  logic [31:0]            prdata_q;
  logic                   osc_q;

  // Bus decode
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wr      = access & pwrite;
  wire sel_ctl = paddr == rrs_pkg::OFF_CTRL;
  wire sel_ir  = paddr == rrs_pkg::OFF_INSTR;
  wire sel_acc = paddr == rrs_pkg::OFF_ACC;
  wire sel_st  = paddr == rrs_pkg::OFF_STATUS;
  wire sel_pc  = paddr == rrs_pkg::OFF_PC;
  wire sel_psh = paddr == rrs_pkg::OFF_PUSH;
  wire sel_fa  = paddr == rrs_pkg::OFF_FADDR;
  wire sel_fd  = paddr == rrs_pkg::OFF_FDATA;
  wire sel_wd  = paddr == rrs_pkg::OFF_WDOG;
  wire mapped  = sel_ctl | sel_ir | sel_acc | sel_st | sel_pc | sel_psh
               | sel_fa | sel_fd | sel_wd;

  // Core state; software writes to it are ignored while busy, except writes to the file address register and wake writes to control in sleep
  wire busy    = (state_q != S_IDLE) | pend_q;
  wire sw_ok   = wr & ~busy;
  wire go      = wr & sel_ctl & pwdata[rrs_pkg::CTRL_GO] & ~busy;
  wire wake    = wr & sel_ctl & pwdata[rrs_pkg::CTRL_WAKE]
               & (state_q == S_SLEEP);

  // Instruction cycle boundaries, four oscillator periods each
  wire q_end   = q_q == rrs_pkg::Q_LAST;
  wire start   = (state_q == S_IDLE) & pend_q & q_end;
  wire two_cyc = (cur_q.op == rrs_pkg::OP_RET_LITERAL)
               | (cur_q.op == rrs_pkg::OP_RETURN);
  wire retire  = (state_q == S_EXEC) & q_end & (cyc_q == two_cyc);

  wire do_ret_lit = retire & (cur_q.op == rrs_pkg::OP_RET_LITERAL);
  wire do_return  = retire & (cur_q.op == rrs_pkg::OP_RETURN);
  wire do_rotate  = retire & (cur_q.op == rrs_pkg::OP_ROTATE_RIGHT);
  wire do_sleep  = retire & (cur_q.op == rrs_pkg::OP_SLEEP);

  // Rotate datapath: old carry into bit 7, old bit 0 out to carry
  wire [7:0] fval   = file_q[cur_q.faddr];
  wire [7:0] rot    = {c_q, fval[7:1]};
  wire       rot_c  = fval[0];
  wire       to_acc = do_rotate & ~cur_q.dest;
  wire       to_f   = do_rotate & cur_q.dest;

  // Stack
  wire [PCW-1:0] stack_head;
  wire [7:0]     stack_depth;
  wire           pop  = do_ret_lit | do_return;
  wire           push = sw_ok & sel_psh;

  return_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PCW)
  ) u_stack (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (push),
    .pop       (pop),
    .push_data (pwdata[PCW-1:0]),
    .head      (stack_head),
    .depth     (stack_depth)
  );

  // Prescaler advances once per instruction cycle while awake; watchdog advances on each prescaler wrap
  wire wd_tick = q_end & (state_q != S_SLEEP);
  wire pre_wrap = &pre_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:  if (start) state_d = S_EXEC;
      S_EXEC:  if (do_sleep) state_d = S_SLEEP;
               else if (retire) state_d = S_IDLE;
      S_SLEEP: if (wake) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      q_q     <= 2'h0;
      cyc_q   <= 1'b0;
      osc_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      q_q     <= (state_d == S_SLEEP) ? 2'h0 : q_q + 2'h1;
      cyc_q   <= (state_q == S_EXEC) & q_end ? ~cyc_q : cyc_q & ~start;
      osc_q   <= state_d != S_SLEEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      ir_q   <= '0;
      cur_q  <= '0;
    end else begin
      pend_q <= go | (pend_q & ~start);
      if (sw_ok & sel_ir) ir_q <= pwdata[rrs_pkg::INSTR_BITS-1:0];
      if (go) cur_q <= ir_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_q <= rrs_pkg::ACC_RST;
      pc_q <= rrs_pkg::PC_RST;
    end else begin
      if (do_ret_lit) w_q <= cur_q.lit;
      else if (to_acc) w_q <= rot;
      else if (sw_ok & sel_acc) w_q <= pwdata[7:0];
      if (pop) pc_q <= stack_head;
      else if (sw_ok & sel_pc) pc_q <= pwdata[PCW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_q             <= rrs_pkg::CARRY_RST;
      sleep_entered_q <= rrs_pkg::SLEEP_ENTERED_RST;
      time_expired_q  <= rrs_pkg::TIME_EXPIRED_RST;
    end else if (do_rotate) begin
      c_q <= rot_c;
    end else if (do_sleep) begin
      sleep_entered_q <= 1'b0;
      time_expired_q  <= 1'b1;
    end else if (sw_ok & sel_st) begin
      c_q             <= pwdata[rrs_pkg::ST_CARRY];
      sleep_entered_q <= pwdata[rrs_pkg::ST_SLEEP_ENTERED];
      time_expired_q  <= pwdata[rrs_pkg::ST_TIME_EXPIRED];
    end
  end

  always_ff @(posedge pclk) begin
    if (to_f) file_q[cur_q.faddr] <= rot;
    else if (sw_ok & sel_fd) file_q[faddr_q] <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      faddr_q <= 7'h00;
      pre_q   <= '0;
      wdog_q  <= '0;
    end else begin
      if (wr & sel_fa) faddr_q <= pwdata[6:0];
      if (do_sleep) begin
        pre_q  <= '0;
        wdog_q <= '0;
      end else if (wd_tick) begin
        pre_q <= pre_q + PRE_WIDTH'(1);
        if (pre_wrap) wdog_q <= wdog_q + WDOG_WIDTH'(1);
      end
    end
  end

  // Read mux, sampled in the setup phase
  wire [31:0] rd_ctl = {29'h0, osc_q, state_q == S_SLEEP, busy};
  wire [31:0] rd_st  = {27'h0, time_expired_q, sleep_entered_q, 2'h0, c_q};
  wire [31:0] rdata  =
      sel_ctl ? rd_ctl :
      sel_ir  ? 32'(ir_q) :
      sel_acc ? {24'h0, w_q} :
      sel_st  ? rd_st :
      sel_pc  ? 32'(pc_q) :
      sel_psh ? {24'h0, stack_depth} :
      sel_fa  ? {25'h0, faddr_q} :
      sel_fd  ? {24'h0, file_q[faddr_q]} :
      sel_wd  ? {16'h0, 8'(pre_q), 8'(wdog_q)} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= 32'h0;
    else if (setup) prdata_q <= rdata;
  end

  assign prdata   = prdata_q;
  assign pready   = 1'b1;
  assign pslverr  = access & ~mapped;
  assign sleeping = state_q == S_SLEEP;
  assign osc_run  = osc_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  lit_load_a: assert property (do_ret_lit |=>
    w_q == $past(cur_q.lit) && pc_q == $past(stack_head))
    else $error("literal return did not load W and PC");

  lit_flags_a: assert property (do_ret_lit |=>
    c_q == $past(c_q) && sleep_entered_q == $past(sleep_entered_q)
    && time_expired_q == $past(time_expired_q))
    else $error("literal return changed a status flag");

  two_cycle_a: assert property (
    start && (cur_q.op == rrs_pkg::OP_RETURN) ##1 1 |-> ##7 retire)
    else $error("return did not take two instruction cycles");

  one_cycle_a: assert property (
    start && (cur_q.op == rrs_pkg::OP_ROTATE_RIGHT) |-> !retire[*4] ##0 1
      ##1 retire)
    else $error("rotate did not take four oscillator periods");

  rotate_value_a: assert property (to_acc |=>
    w_q == {$past(c_q), $past(fval[7:1])} && c_q == $past(fval[0]))
    else $error("rotate right result or carry wrong");

  rotate_dest_a: assert property (to_f |=>
    w_q == $past(w_q)
    && file_q[$past(cur_q.faddr)] == {$past(c_q), $past(fval[7:1])})
    else $error("rotate right written to wrong destination");

  sleep_wdog_a: assert property (do_sleep |=>
    wdog_q == '0 && pre_q == '0)
    else $error("sleep did not clear watchdog");

  sleep_flags_a: assert property (do_sleep |=>
    !sleep_entered_q && time_expired_q && c_q == $past(c_q))
    else $error("sleep flags wrong");

  sleep_osc_a: assert property (do_sleep |=>
    sleeping && !osc_run ##1 (sleeping || !osc_run))
    else $error("sleep did not halt oscillator");

  q_period_a: assert property (
    q_end && !sleeping && !do_sleep |=> !q_end[*3] ##1 (q_end || sleeping))
    else $error("instruction cycle not four periods");

  ret_pc_a: assert property (do_return |=>
    pc_q == $past(stack_head) && w_q == $past(w_q))
    else $error("return did not load PC from stack head");

  ret_flags_a: assert property (do_return |=>
    c_q == $past(c_q) && sleep_entered_q == $past(sleep_entered_q)
    && time_expired_q == $past(time_expired_q))
    else $error("return changed a status flag");

  ret_depth_a: assert property (pop && stack_depth != 8'h00 |=>
    stack_depth == $past(stack_depth) - 8'h01)
    else $error("return did not pop the stack");

  lit_cycles_a: assert property (
    start && cur_q.op == rrs_pkg::OP_RET_LITERAL ##1 1 |-> ##7 do_ret_lit)
    else $error("literal return did not take two instruction cycles");

  rotate_flags_a: assert property (do_rotate |=>
    sleep_entered_q == $past(sleep_entered_q)
    && time_expired_q == $past(time_expired_q))
    else $error("rotate right changed a flag other than carry");

  rotate_keep_a: assert property (to_acc |=>
    file_q[$past(cur_q.faddr)] == $past(fval))
    else $error("rotate right to W changed the file register");

  rotate_carry_a: assert property (do_rotate |=>
    c_q == $past(fval[0]))
    else $error("rotate right carry not taken from bit 0");

  sleep_hold_a: assert property (sleeping && !wake |=>
    sleeping && !osc_run && q_q == 2'h0)
    else $error("sleep state left without wake");

  wdog_frozen_a: assert property (sleeping |=>
    wdog_q == $past(wdog_q) && pre_q == $past(pre_q))
    else $error("watchdog moved during sleep");

  osc_state_a: assert property (osc_run == !sleeping)
    else $error("oscillator running while asleep");

endmodule : return_rotate_sleep_exec

/* return_rotate_sleep_exec_bench.sv */
// Self-checking bench for the return, rotate and sleep executor
`timescale 1ns/1ps
module return_rotate_sleep_exec_bench;
  // Clock and reset
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  // APB
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Power state
  logic        sleeping;
  logic        osc_run;

  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          t;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  f;
  logic [7:0]  lit;
  logic [6:0]  fa;
  logic        c;
  logic        d;
  logic [12:0] ra;
  logic [12:0] rb;

  always #20 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  return_rotate_sleep_exec u_return_rotate_sleep_exec (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleeping(sleeping), .osc_run(osc_run));

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; read data and error taken in the access phase
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Issue one instruction and poll control until (rd & m) == v
  task automatic exec(input logic [31:0] ins, input logic [31:0] m,
                      input logic [31:0] v);
    int n;
    int t0;
    n = 0;
    apb(1'b1, rrs_pkg::OFF_INSTR, ins);
    apb(1'b1, rrs_pkg::OFF_CTRL, 32'h1);
    t0 = cyc;
    do begin
      apb(1'b0, rrs_pkg::OFF_CTRL, 32'h0);
      n++;
    end while ((rd & m) !== v && n < 100);
    if ((rd & m) !== v) begin
      miscompares++;
      end_sim();
    end
    t = cyc - t0;
  endtask : exec

  function automatic logic [31:0] mk(rrs_pkg::op_e op, logic dd,
                                     logic [6:0] a, logic [7:0] l);
    rrs_pkg::instr_s s;
    s.lit = l;
    s.faddr = a;
    s.dest = dd;
    s.op = op;
    return 32'(s);
  endfunction : mk

  function automatic logic [7:0] rot(logic [7:0] v, logic ci);
    return {ci, v[7:1]};
  endfunction : rot

  initial begin
    void'($urandom(28001));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, rrs_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h18);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Rotations with edge patterns first, then random ones
    for (int i = 0; i < 10; i++) begin
      f = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($urandom);
      c = (i == 0) ? 1'b0 : (i == 1) ? 1'b1 : 1'($urandom);
      d = i[0];
      fa = 7'($urandom);
      apb(1'b1, rrs_pkg::OFF_FADDR, {25'h0, fa});
      apb(1'b1, rrs_pkg::OFF_FDATA, {24'h0, f});
      apb(1'b1, rrs_pkg::OFF_ACC, 32'h5a);
      apb(1'b1, rrs_pkg::OFF_STATUS, {31'h0000000c, c});
      exec(mk(rrs_pkg::OP_ROTATE_RIGHT, d, fa, 8'($urandom)), 32'h1, 32'h0);
      chk(32'(t <= 14), 32'h1);
      apb(1'b0, rrs_pkg::OFF_STATUS, 32'h0);
      chk(rd, {27'h0, 2'h3, 2'h0, f[0]});
      apb(1'b0, rrs_pkg::OFF_ACC, 32'h0);
      chk(rd, d ? 32'h5a : {24'h0, rot(f, c)});
      apb(1'b0, rrs_pkg::OFF_FDATA, 32'h0);
      chk(rd, {24'h0, d ? rot(f, c) : f});
    end
    // Literal return then plain return on a two-entry stack
    ra = 13'($urandom);
    rb = 13'($urandom);
    lit = 8'($urandom);
    apb(1'b1, rrs_pkg::OFF_PUSH, {19'h0, ra});
    apb(1'b1, rrs_pkg::OFF_PUSH, {19'h0, rb});
    apb(1'b1, rrs_pkg::OFF_STATUS, 32'h19);
    exec(mk(rrs_pkg::OP_RET_LITERAL, 1'b0, 7'h0, lit), 32'h1, 32'h0);
    chk(32'(t >= 8), 32'h1);
    apb(1'b0, rrs_pkg::OFF_ACC, 32'h0);
    chk(rd, {24'h0, lit});
    apb(1'b0, rrs_pkg::OFF_PC, 32'h0);
    chk(rd, {19'h0, rb});
    apb(1'b0, rrs_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h19);
    exec(mk(rrs_pkg::OP_RETURN, 1'b0, 7'h0, 8'h0), 32'h1, 32'h0);
    chk(32'(t >= 8), 32'h1);
    apb(1'b0, rrs_pkg::OFF_PC, 32'h0);
    chk(rd, {19'h0, ra});
    apb(1'b0, rrs_pkg::OFF_PUSH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, rrs_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h19);
    // Sleep from a state with both power flags low and carry set
    apb(1'b1, rrs_pkg::OFF_STATUS, 32'h01);
    exec(mk(rrs_pkg::OP_SLEEP, 1'b0, 7'h0, 8'h0), 32'h2, 32'h2);
    chk({30'h0, sleeping, osc_run}, 32'h2);
    apb(1'b0, rrs_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h11);
    apb(1'b0, rrs_pkg::OFF_WDOG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, rrs_pkg::OFF_CTRL, 32'h2);
    repeat (2) @(posedge pclk);
    chk({30'h0, sleeping, osc_run}, 32'h1);
    end_sim();
  end
endmodule : return_rotate_sleep_exec_bench
